// *** rtl/udfc_params.svh ***
`ifndef UDFC_PARAMS_SVH
`define UDFC_PARAMS_SVH

// Register offsets on the management register port.
`define UDFC_OFS_UCAST 8'h83
`define UDFC_OFS_MCAST 8'h84
`define UDFC_OFS_VLAN 8'h85
`define UDFC_OFS_IPMC 8'h86
`define UDFC_OFS_GC19 8'h87

// Field positions.
`define UDFC_MAP_MSB 4
`define UDFC_EN_BIT 5
`define UDFC_SELF_BIT 6
`define UDFC_DRIVE_LSB 6
`define UDFC_RATE_LSB 4
`define UDFC_QEGR_BIT 3
`define UDFC_PVID_BIT 2

// Reset values of the map, drive and rate fields.
`define UDFC_RST_MAP 5'h00
`define UDFC_RST_DRIVE 2'h1
`define UDFC_RST_RATE 2'h1

// Unmapped reads return this value.
`define UDFC_RD_NONE 8'h00

`endif

// *** rtl/udfc_pkg.sv ***
package udfc_pkg;

   // One lookup result handed over by the forwarding engine.
   typedef struct packed {
      logic self_src_match;
      logic unknown_vid;
      logic unknown_dest;
      logic is_multicast;
      logic is_ip_multicast;
      logic [4:0] resolved_map;
   } udfc_req_t;

   // Final egress decision.
   typedef struct packed {
      logic drop;
      logic [4:0] egress_map;
   } udfc_res_t;

   // One class enable with its port map.
   typedef struct packed {
      logic enable;
      logic [4:0] port_map;
   } udfc_cls_t;

endpackage : udfc_pkg

// *** rtl/udfc_top.sv ***
`timescale 1ns/10ps
`include "udfc_params.svh"

module udfc_top (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic reset_in,
   // Management register port.
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Lookup result from the forwarding engine.
   input wire logic req_valid_in,
   input wire udfc_pkg::udfc_req_t req_in,
   // Egress decision.
   output logic res_valid_out,
   output udfc_pkg::udfc_res_t res_out,
   // Configuration fields used by neighbouring logic.
   output logic [1:0] drive_strength_out,
   output logic [1:0] rate_period_out,
   output logic queue_egress_out,
   output logic pvid_select_out
);
   import udfc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register storage.

   udfc_cls_t ucast_cls;
   udfc_cls_t mcast_cls;
   udfc_cls_t vlan_cls;
   udfc_cls_t ipmc_cls;
   logic self_filter;

   wire hit_ucast = reg_addr_in == `UDFC_OFS_UCAST;
   wire hit_mcast = reg_addr_in == `UDFC_OFS_MCAST;
   wire hit_vlan = reg_addr_in == `UDFC_OFS_VLAN;
   wire hit_ipmc = reg_addr_in == `UDFC_OFS_IPMC;
   wire hit_gc19 = reg_addr_in == `UDFC_OFS_GC19;

   wire udfc_cls_t wr_cls = '{enable: reg_wdata_in[`UDFC_EN_BIT],
                              port_map: reg_wdata_in[`UDFC_MAP_MSB:0]};

   // Only writable fields are stored, so reserved bits cannot be changed.
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         ucast_cls <= '0;
         mcast_cls <= '0;
         vlan_cls <= '0;
         ipmc_cls <= '0;
         self_filter <= 1'b0;
         drive_strength_out <= `UDFC_RST_DRIVE;
         rate_period_out <= `UDFC_RST_RATE;
         queue_egress_out <= 1'b0;
         pvid_select_out <= 1'b0;
      end else if (reg_wr_in) begin
         if (hit_ucast) begin
            ucast_cls <= wr_cls;
         end else if (hit_mcast) begin
            mcast_cls <= wr_cls;
            drive_strength_out <= reg_wdata_in[`UDFC_DRIVE_LSB +: 2];
         end else if (hit_vlan) begin
            vlan_cls <= wr_cls;
         end else if (hit_ipmc) begin
            ipmc_cls <= wr_cls;
            self_filter <= reg_wdata_in[`UDFC_SELF_BIT];
         end else if (hit_gc19) begin
            rate_period_out <= reg_wdata_in[`UDFC_RATE_LSB +: 2];
            queue_egress_out <= reg_wdata_in[`UDFC_QEGR_BIT];
            pvid_select_out <= reg_wdata_in[`UDFC_PVID_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path; reserved bits read as zero.

   wire [7:0] rd_ucast = {2'h0, ucast_cls.enable, ucast_cls.port_map};
   wire [7:0] rd_mcast = {drive_strength_out, mcast_cls.enable, mcast_cls.port_map};
   wire [7:0] rd_vlan = {2'h0, vlan_cls.enable, vlan_cls.port_map};
   wire [7:0] rd_ipmc = {1'b0, self_filter, ipmc_cls.enable, ipmc_cls.port_map};
   wire [7:0] rd_gc19 = {2'h0, rate_period_out, queue_egress_out, pvid_select_out, 2'h0};

   logic [7:0] next_rdata;
   always_comb begin
      if (hit_ucast) begin
         next_rdata = rd_ucast;
      end else if (hit_mcast) begin
         next_rdata = rd_mcast;
      end else if (hit_vlan) begin
         next_rdata = rd_vlan;
      end else if (hit_ipmc) begin
         next_rdata = rd_ipmc;
      end else if (hit_gc19) begin
         next_rdata = rd_gc19;
      end else begin
         next_rdata = `UDFC_RD_NONE;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rvalid_out <= reg_rd_in;
         if (reg_rd_in) begin
            reg_rdata_out <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Forwarding decision.

   // A VLAN miss outranks an address miss: the frame cannot be placed in any
   // domain, so its address lookup result is meaningless.
   wire self_drop = self_filter & req_in.self_src_match;
   wire use_vlan = vlan_cls.enable & req_in.unknown_vid;
   wire use_ipmc = ipmc_cls.enable & req_in.unknown_dest & req_in.is_ip_multicast;
   wire use_mcast = mcast_cls.enable & req_in.unknown_dest & req_in.is_multicast
                    & ~req_in.is_ip_multicast;
   wire use_ucast = ucast_cls.enable & req_in.unknown_dest & ~req_in.is_multicast;

   // Each map bit n is port n+1; zero means the frame goes nowhere.
   wire [4:0] next_map = use_vlan ? vlan_cls.port_map :
                         use_ipmc ? ipmc_cls.port_map :
                         use_mcast ? mcast_cls.port_map :
                         use_ucast ? ucast_cls.port_map :
                         req_in.resolved_map;
   wire next_drop = self_drop | (next_map == 5'h00);

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         res_valid_out <= 1'b0;
         res_out <= '0;
      end else begin
         res_valid_out <= req_valid_in;
         if (req_valid_in) begin
            res_out.drop <= next_drop;
            res_out.egress_map <= self_drop ? 5'h00 : next_map;
         end
      end
   end

endmodule : udfc_top

// *** tb/udfc_assertions.sv ***
`timescale 1ns/10ps
module udfc_checker (
   // Watched ports.
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic req_valid_in,
   input wire udfc_pkg::udfc_req_t req_in,
   input wire logic res_valid_out,
   input wire udfc_pkg::udfc_res_t res_out,
   input wire logic [1:0] drive_strength_out
);
   import udfc_pkg::*;
   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);
   sequence rd_s(a); reg_rd_in && reg_addr_in == a ##1 reg_rvalid_out; endsequence
   //////////////////////////////////////////////////
   rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out) else $error("Read unanswered.");
   res_answer_a: assert property (req_valid_in |=> res_valid_out) else $error("No result.");
   res_hold_a: assert property (!req_valid_in |=> $stable(res_out)) else $error("Result moved.");
   drop_map_a: assert property (res_valid_out |-> res_out.drop == (res_out.egress_map == 5'h00))
      else $error("Drop and map disagree.");
   resv_ucast_a: assert property (rd_s(8'h83) |-> reg_rdata_out[7:6] == 2'h0) else $error("Bad bits.");
   resv_last_a: assert property (rd_s(8'h87) |-> reg_rdata_out[7:6] == 2'h0 && reg_rdata_out[1:0] == 2'h0)
      else $error("Bad reserved bits.");
   drive_hold_a: assert property (!(reg_wr_in && reg_addr_in == 8'h84) |=> $stable(drive_strength_out))
      else $error("Drive field moved.");
   known_pass_a: assert property (req_valid_in && !req_in.self_src_match && !req_in.unknown_vid &&
      !req_in.unknown_dest |=> res_out.egress_map == $past(req_in.resolved_map))
      else $error("Resolved map lost.");
endmodule : udfc_checker
bind udfc_top udfc_checker i_udfc_checker (.*);

// *** tb/unknown_dest_forward_control_tb.sv ***
`timescale 1ns/10ps
module unknown_dest_forward_control_tb;
   import udfc_pkg::*;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out;
   logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, req_valid_in = 1'b0;
   udfc_req_t req_in = '0;
   udfc_res_t res_out;
   logic reg_rvalid_out, res_valid_out, queue_egress_out, pvid_select_out;
   logic [1:0] drive_strength_out, rate_period_out;
   logic [4:0] maps [5] = '{5'h00, 5'h01, 5'h03, 5'h1f, 5'h0c};
   int fail_count = 0, total_checks = 0, cyc = 0;
   udfc_top i_udfc_top (.*);
   initial forever #5 clock_in = ~clock_in;
   //////////////////////////////////////////////////
   task report_and_stop;
      $display("Checks %0d, errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   task chk(input string n, input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, d);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, e);
      @(posedge clock_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 chk("rdata", reg_rdata_out, e);
      chk("rvalid", {7'h0, reg_rvalid_out}, 8'h01);
   endtask : rd
   task look(input udfc_req_t q, input logic [7:0] e);
      @(posedge clock_in);
      req_in <= q;
      req_valid_in <= 1'b1;
      @(posedge clock_in);
      req_valid_in <= 1'b0;
      #1 chk("valid", {7'h0, res_valid_out}, 8'h01);
      chk("result", {2'h0, res_out}, e);
   endtask : look
   // Every class runs the same map table, then is disabled to show pass-through.
   task sweep(input logic [7:0] a, w, e, input udfc_req_t q);
      for (int i = 0; i < 5; i++) begin
         wr(a, w | maps[i]);
         rd(a, e | maps[i]);
         look(q, {2'h0, maps[i] == 5'h00, maps[i]});
      end
      wr(a, 8'h00);
      look(q, 8'h15);
   endtask : sweep
   task t_reset;
      rd(8'h83, 8'h00);
      rd(8'h84, 8'h40);
      rd(8'h85, 8'h00);
      rd(8'h86, 8'h00);
      rd(8'h87, 8'h10);
      rd(8'h88, 8'h00);
      wr(8'h87, 8'hff);
      rd(8'h87, 8'h3c);
      chk("fields", {4'h0, rate_period_out, queue_egress_out, pvid_select_out}, 8'h0f);
   endtask : t_reset
   task t_ucast;
      sweep(8'h83, 8'he0, 8'h20, 10'h095);
   endtask : t_ucast
   task t_mcast;
      sweep(8'h84, 8'h60, 8'h60, 10'h0d5);
      chk("drive", {6'h0, drive_strength_out}, 8'h00);
      wr(8'h84, 8'h61);
      look(10'h0f5, 8'h15);
   endtask : t_mcast
   task t_vlan;
      sweep(8'h85, 8'he0, 8'h20, 10'h115);
   endtask : t_vlan
   task t_ipmc;
      sweep(8'h86, 8'ha0, 8'h20, 10'h0f5);
   endtask : t_ipmc
   task t_self;
      wr(8'h86, 8'h40);
      look(10'h215, 8'h20);
      look(10'h015, 8'h15);
      wr(8'h86, 8'h00);
      look(10'h215, 8'h15);
   endtask : t_self
   always @(posedge clock_in) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count++;
         report_and_stop();
      end
   end
   initial begin
      repeat (12) @(posedge clock_in);
      reset_in <= 1'b0;
      t_reset();
      t_ucast();
      t_mcast();
      t_vlan();
      t_ipmc();
      t_self();
      report_and_stop();
   end
endmodule : unknown_dest_forward_control_tb
